/* logic/pwm_ctl_regs.svh */
// register offsets, field positions, reset values, full-scale value and bus response codes for the pwm control block
`ifndef PWM_CTL_REGS_SVH
`define PWM_CTL_REGS_SVH

// printed offsets are register indices; byte address is four times the index
`define IDX_PWM_CONTROL        4'h5
`define IDX_FACTORY_TEST       4'h6
`define IDX_PRESCALER_TEST     4'h7
`define IDX_CLOCK_A_SCALE      4'h8
`define IDX_CLOCK_B_SCALE      4'h9
`define IDX_SCALE_CNT_A_TEST   4'hA
`define IDX_SCALE_CNT_B_TEST   4'hB
`define IDX_CLOCK_SELECT       4'h2
`define IDX_PRESCALE_SELECT    4'h3
`define IDX_STATUS             4'hC

`define BIT_PAIR_HI_JOIN       5
`define BIT_PAIR_LO_JOIN       4
`define BIT_WAIT_HALT          3
`define BIT_DEBUG_HALT         2
`define PRESCALE_A_LSB         0
`define PRESCALE_B_LSB         4

`define RST_PWM_CONTROL        8'h00
`define RST_CLOCK_SELECT       8'h00
`define RST_PRESCALE_SELECT    8'h00
`define RST_SCALE              8'h00
`define SCALE_FULL             9'h100
`define RESERVED_READ          8'h00

`define AXI_RESP_OKAY          2'h0
`define AXI_RESP_SLVERR        2'h2

`endif

/* logic/pwm_ctl_pkg.sv */
// types shared by the pwm control block
package pwm_ctl_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [3:0] chan_t;
    typedef enum logic [1:0] {
        WR_IDLE,
        WR_RESP
    } wr_state_t;
endpackage

/* logic/pwm_scaler.sv */
// scale counter that divides a prescaled clock tick by the scale value
`timescale 1ns/1ps
`default_nettype none
`include "pwm_ctl_regs.svh"
module pwm_scaler (
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    // control
    input  wire logic       tick,
    input  wire logic       load,
    input  wire logic [7:0] scale,
    // result
    output logic            scaled_tick,
    output logic [7:0]      count
);
    logic [8:0] reload;

    // zero stands for full scale of 256
    assign reload = (scale == 8'h00) ? `SCALE_FULL : {1'b0, scale};

    // count down on each input tick; reload and emit a half-period tick at terminal count
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            count       <= 8'h00;
            scaled_tick <= 1'b0;
        end else begin
            scaled_tick <= 1'b0;
            if (load) begin
                count <= 8'(reload - 9'h001);
            end else if (tick) begin
                if (count == 8'h00) begin
                    count       <= 8'(reload - 9'h001);
                    scaled_tick <= 1'b1;
                end else begin
                    count <= count - 8'h01;
                end
            end
        end
    end
endmodule
`default_nettype wire

/* logic/pwm_ctl.sv */
// pwm control, prescaler and scaled clock generation with an axi4-lite register slave
//
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "pwm_ctl_regs.svh"
module pwm_ctl
    import pwm_ctl_pkg::*;
#(
    parameter int ADDR_W = 6
) (
    // clock and reset
    input  wire logic              core_clk,
    input  wire logic              rst_n,
    // mode inputs from outside the clock domain
    input  wire logic              wait_mode,
    input  wire logic              freeze_mode,
    // axi4-lite write address
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    // axi4-lite write data
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    // axi4-lite write response
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    output logic [1:0]             s_axi_bresp,
    // axi4-lite read address
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    // axi4-lite read data
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    // per-channel clock ticks to the channel counters
    output pwm_ctl_pkg::chan_t     chan_tick,
    // concatenation controls to the channel logic
    output logic                   pair_lo_join,
    output logic                   pair_hi_join,
    // which channels own their control bits and output pin
    output pwm_ctl_pkg::chan_t     chan_active
);
    import pwm_ctl_pkg::*;

    byte_t      pwm_control;
    byte_t      clock_select;
    byte_t      prescale_select;
    byte_t      clock_a_scale_value;
    byte_t      clock_b_scale_value;
    logic [1:0] wait_sync;
    logic [1:0] freeze_sync;
    logic       prescale_run;
    logic [6:0] prescale_cnt;
    logic [6:0] next_prescale_cnt;
    logic       tick_a;
    logic       tick_b;
    logic       scaled_tick_a;
    logic       scaled_tick_b;
    logic       scaled_level_a;
    logic       scaled_level_b;
    logic       sa_rise;
    logic       sb_rise;
    byte_t      scale_cnt_a;
    byte_t      scale_cnt_b;
    wr_state_t  wr_state;
    logic       aw_held;
    logic       w_held;
    logic [3:0] aw_idx;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic       wr_fire;
    logic       wr_hit;
    logic [3:0] ar_idx;
    logic       rd_hit;
    byte_t      rd_byte;
    logic       wr_scale_a;
    logic       wr_scale_b;
    chan_t      next_chan_tick;

    // mode levels cross in through two flip-flops
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_sync   <= 2'h0;
            freeze_sync <= 2'h0;
        end else begin
            wait_sync   <= {wait_sync[0], wait_mode};
            freeze_sync <= {freeze_sync[0], freeze_mode};
        end
    end

    // prescaler input gated by wait and freeze; resumes once the bit or mode clears
    assign prescale_run = !(pwm_control[`BIT_WAIT_HALT] && wait_sync[1])
                       && !(pwm_control[`BIT_DEBUG_HALT] && freeze_sync[1]);

    assign next_prescale_cnt = prescale_cnt + 7'h01;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            prescale_cnt <= 7'h00;
        end else if (prescale_run) begin
            prescale_cnt <= next_prescale_cnt;
        end
    end

    // tick once every 2^field bus clocks: low field bits of the count all ones
    function automatic logic prescale_tick(input logic [6:0] cnt, input logic [2:0] sel);
        logic [6:0] mask;
        mask = 7'((8'h01 << sel) - 8'h01);
        return (cnt & mask) == mask;
    endfunction

    assign tick_a = prescale_run && prescale_tick(prescale_cnt, prescale_select[`PRESCALE_A_LSB +: 3]);
    assign tick_b = prescale_run && prescale_tick(prescale_cnt, prescale_select[`PRESCALE_B_LSB +: 3]);

    assign wr_scale_a = wr_fire && wr_hit && aw_idx == `IDX_CLOCK_A_SCALE && w_strb[0];
    assign wr_scale_b = wr_fire && wr_hit && aw_idx == `IDX_CLOCK_B_SCALE && w_strb[0];

    pwm_scaler u_scaler_a (
        .core_clk    (core_clk),
        .rst_n       (rst_n),
        .tick        (tick_a),
        .load        (wr_scale_a),
        .scale       (wr_scale_a ? w_data[7:0] : clock_a_scale_value),
        .scaled_tick (scaled_tick_a),
        .count       (scale_cnt_a)
    );

    pwm_scaler u_scaler_b (
        .core_clk    (core_clk),
        .rst_n       (rst_n),
        .tick        (tick_b),
        .load        (wr_scale_b),
        .scale       (wr_scale_b ? w_data[7:0] : clock_b_scale_value),
        .scaled_tick (scaled_tick_b),
        .count       (scale_cnt_b)
    );

    // scaled clock levels toggle at each terminal count
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            scaled_level_a <= 1'b0;
            scaled_level_b <= 1'b0;
        end else begin
            if (scaled_tick_a) begin
                scaled_level_a <= !scaled_level_a;
            end
            if (scaled_tick_b) begin
                scaled_level_b <= !scaled_level_b;
            end
        end
    end

    assign sa_rise = scaled_tick_a && !scaled_level_a;  // one tick per full scaled period
    assign sb_rise = scaled_tick_b && !scaled_level_b;

    // per-channel clock pick; a merged pair follows the odd channel's select
    always_comb begin
        next_chan_tick = 4'h0;
        for (int i = 0; i < 4; i++) begin
            if (i < 2) begin
                next_chan_tick[i] = clock_select[i] ? sa_rise : tick_a;
            end else begin
                next_chan_tick[i] = clock_select[i] ? sb_rise : tick_b;
            end
        end
        if (pwm_control[`BIT_PAIR_LO_JOIN]) begin
            next_chan_tick[0] = next_chan_tick[1];
        end
        if (pwm_control[`BIT_PAIR_HI_JOIN]) begin
            next_chan_tick[2] = next_chan_tick[3];
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            chan_tick    <= 4'h0;
            pair_lo_join <= 1'b0;
            pair_hi_join <= 1'b0;
            chan_active  <= 4'hF;
        end else begin
            chan_tick    <= next_chan_tick;
            pair_lo_join <= pwm_control[`BIT_PAIR_LO_JOIN];
            pair_hi_join <= pwm_control[`BIT_PAIR_HI_JOIN];
            chan_active  <= {1'b1, !pwm_control[`BIT_PAIR_HI_JOIN],
                             1'b1, !pwm_control[`BIT_PAIR_LO_JOIN]};
        end
    end

    // write path: address and data taken in either order
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_held <= 1'b0;
            aw_idx  <= 4'h0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_idx  <= s_axi_awaddr[5:2];
        end else if (wr_fire) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            w_held <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_held <= 1'b0;
        end
    end

    // a ready drops once its half is taken and returns when the response is accepted
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
        end else begin
            s_axi_awready <= (wr_state == WR_RESP && s_axi_bready) || (s_axi_awready && !s_axi_awvalid);
            s_axi_wready  <= (wr_state == WR_RESP && s_axi_bready) || (s_axi_wready && !s_axi_wvalid);
        end
    end

    assign wr_fire       = aw_held && w_held;
    assign wr_hit        = aw_idx inside {`IDX_PWM_CONTROL, `IDX_CLOCK_SELECT, `IDX_PRESCALE_SELECT,
                                          `IDX_CLOCK_A_SCALE, `IDX_CLOCK_B_SCALE, `IDX_FACTORY_TEST,
                                          `IDX_PRESCALER_TEST, `IDX_SCALE_CNT_A_TEST, `IDX_SCALE_CNT_B_TEST};

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_state     <= WR_IDLE;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `AXI_RESP_OKAY;
        end else begin
            case (wr_state)
                WR_IDLE: begin
                    if (wr_fire) begin
                        wr_state     <= WR_RESP;
                        s_axi_bvalid <= 1'b1;
                        s_axi_bresp  <= wr_hit ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
                    end
                end
                WR_RESP: begin
                    if (s_axi_bready) begin
                        wr_state     <= WR_IDLE;
                        s_axi_bvalid <= 1'b0;
                    end
                end
                default: begin
                    wr_state <= WR_IDLE;
                end
            endcase
        end
    end

    // register storage; factory-test writes are dropped
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pwm_control         <= `RST_PWM_CONTROL;
            clock_select        <= `RST_CLOCK_SELECT;
            prescale_select     <= `RST_PRESCALE_SELECT;
            clock_a_scale_value <= `RST_SCALE;
            clock_b_scale_value <= `RST_SCALE;
        end else if (wr_fire && w_strb[0]) begin
            case (aw_idx)
                `IDX_PWM_CONTROL:     pwm_control         <= w_data[7:0] & 8'h3C;
                `IDX_CLOCK_SELECT:    clock_select        <= w_data[7:0] & 8'h0F;
                `IDX_PRESCALE_SELECT: prescale_select     <= w_data[7:0] & 8'h77;
                `IDX_CLOCK_A_SCALE:   clock_a_scale_value <= w_data[7:0];
                `IDX_CLOCK_B_SCALE:   clock_b_scale_value <= w_data[7:0];
                default:              pwm_control         <= pwm_control;
            endcase
        end
    end

    // read path: one word answered the cycle after the address is taken
    assign ar_idx = s_axi_araddr[5:2];
    always_comb begin
        rd_hit  = 1'b1;
        rd_byte = `RESERVED_READ;
        case (ar_idx)
            `IDX_PWM_CONTROL:     rd_byte = pwm_control;
            `IDX_CLOCK_SELECT:    rd_byte = clock_select;
            `IDX_PRESCALE_SELECT: rd_byte = prescale_select;
            `IDX_CLOCK_A_SCALE:   rd_byte = clock_a_scale_value;
            `IDX_CLOCK_B_SCALE:   rd_byte = clock_b_scale_value;
            `IDX_STATUS:          rd_byte = {4'h0, !prescale_run, freeze_sync[1], wait_sync[1],
                                             scaled_level_a ^ scaled_level_b};
            `IDX_FACTORY_TEST, `IDX_PRESCALER_TEST,
            `IDX_SCALE_CNT_A_TEST, `IDX_SCALE_CNT_B_TEST: rd_byte = `RESERVED_READ;
            default:              rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `AXI_RESP_OKAY;
            s_axi_arready <= 1'b1;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= {24'h00_0000, rd_byte};
            s_axi_rresp   <= rd_hit ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
            s_axi_arready <= 1'b0;
        end else if (s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    sequence seq_scale_write;
        wr_scale_a;
    endsequence

    chk_wait_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
        (pwm_control[`BIT_WAIT_HALT] && wait_sync[1]) |-> !tick_a && !tick_b)
        else $error("prescaler ticked in wait mode with halt set");
    chk_freeze_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
        (pwm_control[`BIT_DEBUG_HALT] && freeze_sync[1]) |=> $stable(prescale_cnt))
        else $error("prescaler moved in freeze with halt set");
    chk_freeze_resume: assert property (@(posedge core_clk) disable iff (!rst_n)
        (!freeze_sync[1] && !wait_sync[1]) |=> prescale_cnt != $past(prescale_cnt))
        else $error("prescaler did not resume");
    chk_test_read_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
        (s_axi_arvalid && s_axi_arready && ar_idx inside {`IDX_FACTORY_TEST, `IDX_SCALE_CNT_A_TEST})
        |=> s_axi_rdata == 32'h0000_0000)
        else $error("reserved register did not read zero");
    chk_scale_reload: assert property (@(posedge core_clk) disable iff (!rst_n)
        seq_scale_write |=> scale_cnt_a == 8'($past(w_data[7:0] == 8'h00 ? `SCALE_FULL : {1'b0, w_data[7:0]}) - 9'h001))
        else $error("scale a counter not reloaded on write");
    chk_scale_reload_b: assert property (@(posedge core_clk) disable iff (!rst_n)
        wr_scale_b |=> scale_cnt_b == 8'($past(w_data[7:0] == 8'h00 ? `SCALE_FULL : {1'b0, w_data[7:0]}) - 9'h001))
        else $error("scale b counter not reloaded on write");
    chk_ch0_scaled_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (clock_select[0] && !pwm_control[`BIT_PAIR_LO_JOIN]) |=> chan_tick[0] == $past(sa_rise))
        else $error("channel 0 tick not from scaled clock a");
    chk_join_hi: assert property (@(posedge core_clk) disable iff (!rst_n)
        pwm_control[`BIT_PAIR_HI_JOIN] |=> chan_tick[2] == chan_tick[3])
        else $error("merged 2/3 channel ticks disagree");
    chk_join_lo: assert property (@(posedge core_clk) disable iff (!rst_n)
        pwm_control[`BIT_PAIR_LO_JOIN] |=> chan_tick[0] == chan_tick[1] && !chan_active[0])
        else $error("merged 0/1 channel not following channel 1");
endmodule
`default_nettype wire

/* verification/pwm_control_and_scaled_clocks_tb_top.sv */
// self-checking bench for the pwm control block through its axi4-lite register port
`timescale 1ns/1ps
`default_nettype none
`include "pwm_ctl_regs.svh"
module pwm_control_and_scaled_clocks_tb_top;
    import pwm_ctl_pkg::*;
    logic        core_clk;
    logic        rst_n;
    logic        wait_mode;
    logic        freeze_mode;
    logic        s_axi_awvalid;
    logic        s_axi_awready;
    logic [5:0]  s_axi_awaddr;
    logic        s_axi_wvalid;
    logic        s_axi_wready;
    logic [31:0] s_axi_wdata;
    logic [3:0]  s_axi_wstrb;
    logic        s_axi_bvalid;
    logic        s_axi_bready;
    logic [1:0]  s_axi_bresp;
    logic        s_axi_arvalid;
    logic        s_axi_arready;
    logic [5:0]  s_axi_araddr;
    logic        s_axi_rvalid;
    logic        s_axi_rready;
    logic [31:0] s_axi_rdata;
    logic [1:0]  s_axi_rresp;
    chan_t       chan_tick;
    logic        pair_lo_join;
    logic        pair_hi_join;
    chan_t       chan_active;
    int          n_mismatch;
    int          checks;
    logic [31:0] rd;
    logic [1:0]  resp;
    int          p;
    int          c;
    logic [5:0]  rsvd_addr [4] = '{6'h18, 6'h1C, 6'h28, 6'h2C};

    pwm_ctl #(.ADDR_W(6)) dut_u (
        .core_clk      (core_clk),
        .rst_n         (rst_n),
        .wait_mode     (wait_mode),
        .freeze_mode   (freeze_mode),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .chan_tick     (chan_tick),
        .pair_lo_join  (pair_lo_join),
        .pair_hi_join  (pair_hi_join),
        .chan_active   (chan_active)
    );

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("compares %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic timed_out();
        n_mismatch++;
        $display("BAD %0t wait ran out", $time);
        conclude();
    endtask

    // every task is entered and left just after a rising edge
    task automatic axi_write(input logic [5:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        s_axi_awvalid <= 1'b1;
        s_axi_awaddr  <= a;
        s_axi_wvalid  <= 1'b1;
        s_axi_wdata   <= d;
        s_axi_bready  <= 1'b1;
        forever begin
            @(posedge core_clk);
            n++;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && s_axi_bready) break;
            if (n > 100) timed_out();
        end
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic axi_read(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        s_axi_arvalid <= 1'b1;
        s_axi_araddr  <= a;
        s_axi_rready  <= 1'b1;
        forever begin
            @(posedge core_clk);
            n++;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && s_axi_rready) break;
            if (n > 100) timed_out();
        end
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        logic [1:0] r;
        axi_write(a, d, r);
        check({30'h0, r}, {30'h0, `AXI_RESP_OKAY});
    endtask

    // cycles between two consecutive ticks of one channel
    task automatic measure(input int ch, output int per);
        int n;
        n = 0;
        // the first tick may still belong to the schedule before the last write
        repeat (2) begin
            do begin
                @(posedge core_clk);
                n++;
            end while (chan_tick[ch] !== 1'b1 && n < 4000);
        end
        per = 0;
        do begin
            @(posedge core_clk);
            per++;
        end while (chan_tick[ch] !== 1'b1 && per < 2000);
        if (n >= 4000 || per >= 2000) timed_out();
    endtask

    task automatic count_ticks(input int ch, input int cyc, output int cnt);
        cnt = 0;
        repeat (cyc) begin
            @(posedge core_clk);
            if (chan_tick[ch] === 1'b1) cnt++;
        end
    endtask

    initial begin
        n_mismatch = 0;
        checks = 0;
        rst_n = 1'b0;
        wait_mode = 1'b0;
        freeze_mode = 1'b0;
        s_axi_awvalid = 1'b0;
        s_axi_awaddr = 6'h00;
        s_axi_wvalid = 1'b0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hF;
        s_axi_bready = 1'b0;
        s_axi_arvalid = 1'b0;
        s_axi_araddr = 6'h00;
        s_axi_rready = 1'b0;
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        check({28'h0, chan_active}, 32'hF);
        // reserved test registers ignore writes and read zero
        for (int i = 0; i < 4; i++) begin
            wr(rsvd_addr[i], 32'hFF);
            axi_read(rsvd_addr[i], rd, resp);
            check(rd, 32'h0);
        end
        axi_write(6'h3C, 32'h1, resp);
        check({30'h0, resp}, {30'h0, `AXI_RESP_SLVERR});
        axi_read(6'h3C, rd, resp);
        check({30'h0, resp}, {30'h0, `AXI_RESP_SLVERR});
        // every combination of the two join bits
        for (int j = 0; j < 4; j++) begin
            wr(6'h14, {26'h0, j[1], j[0], 4'h0});
            repeat (3) @(posedge core_clk);
            check({31'h0, pair_lo_join}, {31'h0, j[0]});
            check({31'h0, pair_hi_join}, {31'h0, j[1]});
            check({28'h0, chan_active}, {28'h0, 1'b1, ~j[1], 1'b1, ~j[0]});
        end
        wr(6'h14, 32'h0);
        // channels 0 and 2 on scaled clocks, 1 and 3 on plain prescaled clocks
        wr(6'h08, 32'h5);
        wr(6'h0C, 32'h72);
        measure(1, p);
        check(p, 4);
        measure(3, p);
        check(p, 128);
        wr(6'h0C, 32'h00);
        measure(1, p);
        check(p, 1);
        // scale counters of clock A (channel 0) and clock B (channel 2)
        for (int i = 0; i < 2; i++) begin
            wr(6'h20 + 6'(4 * i), 32'h3);
            measure(2 * i, p);
            check(p, 6);
            wr(6'h20 + 6'(4 * i), 32'h0);
            measure(2 * i, p);
            check(p, 512);
            wr(6'h20 + 6'(4 * i), 32'd200);
            repeat (20) @(posedge core_clk);
            wr(6'h20 + 6'(4 * i), 32'h5);
            count_ticks(2 * i, 16, c);
            check(c != 0, 1);
            measure(2 * i, p);
            check(p, 10);
            axi_read(6'h20 + 6'(4 * i), rd, resp);
            check(rd, 32'h5);
        end
        // wait mode gating
        wr(6'h14, 32'h08);
        wait_mode <= 1'b1;
        repeat (6) @(posedge core_clk);
        count_ticks(1, 20, c);
        check(c, 0);
        axi_read(6'h30, rd, resp);
        check(rd & 32'hE, 32'hA);
        wr(6'h14, 32'h00);
        measure(1, p);
        check(p, 1);
        wait_mode <= 1'b0;
        // freeze mode gating, release by leaving freeze and by clearing the bit
        wr(6'h14, 32'h04);
        freeze_mode <= 1'b1;
        repeat (6) @(posedge core_clk);
        count_ticks(1, 20, c);
        check(c, 0);
        axi_read(6'h14, rd, resp);
        check(rd, 32'h04);
        freeze_mode <= 1'b0;
        repeat (6) @(posedge core_clk);
        measure(1, p);
        check(p, 1);
        freeze_mode <= 1'b1;
        repeat (6) @(posedge core_clk);
        count_ticks(1, 10, c);
        check(c, 0);
        wr(6'h14, 32'h00);
        measure(1, p);
        check(p, 1);
        freeze_mode <= 1'b0;
        conclude();
    end
endmodule
`default_nettype wire
